// ---- hw/ppd_pkg.sv ----
// constants for the port pin drive and interrupt block
package ppd_pkg;
    localparam int NPIN = 8;
    localparam int NOE  = 16;
    // register byte offsets
    localparam logic [11:0] OFS_DR    = 12'h000;
    localparam logic [11:0] OFS_DM0   = 12'h004;
    localparam logic [11:0] OFS_DM1   = 12'h008;
    localparam logic [11:0] OFS_DM2   = 12'h00C;
    localparam logic [11:0] OFS_SLW   = 12'h010;
    localparam logic [11:0] OFS_BYP   = 12'h014;
    localparam logic [11:0] OFS_BIE   = 12'h018;
    localparam logic [11:0] OFS_INDIS = 12'h01C;
    localparam logic [11:0] OFS_CTL   = 12'h020;
    localparam logic [11:0] OFS_PS    = 12'h024;
    localparam logic [11:0] OFS_ITYP  = 12'h028;
    localparam logic [11:0] OFS_ISTAT = 12'h02C;
    localparam logic [11:0] OFS_SIOREG = 12'h030;
    localparam logic [11:0] OFS_OESEL = 12'h040;
    localparam logic [11:0] OFS_PIN   = 12'h080;
    // pin form field positions
    localparam int PF_DR = 0;
    localparam int PF_PS = 1;
    localparam int PF_DM = 2;
    localparam int PF_SLW = 5;
    localparam int PF_BIE = 6;
    localparam int PF_BYP = 7;
    // drive mode codes
    typedef enum logic [2:0] {
        DM_HIZ_ANA = 3'h0,
        DM_HIZ_DIG = 3'h1,
        DM_RES_UP  = 3'h2,
        DM_RES_DN  = 3'h3,
        DM_OD_LO   = 3'h4,
        DM_OD_HI   = 3'h5,
        DM_STRONG  = 3'h6,
        DM_RES_UD  = 3'h7
    } ppd_mode_t;
    // interrupt type codes
    localparam logic [1:0] IT_NONE = 2'h0;
    localparam logic [1:0] IT_RISE = 2'h1;
    localparam logic [1:0] IT_FALL = 2'h2;
    localparam logic [1:0] IT_BOTH = 2'h3;
endpackage

// ---- hw/ppd_port.sv ----
// port pin drive, bypass, bidirectional control and edge interrupts
//
// Behaviour
// - each pin has a three-bit drive mode
// - mode zero at reset: no drive, input off
// - mode one: high-z, input buffer on
// - pull-up/pull-down modes: resistive plus strong
// - open-drain low and high modes
// - strong mode drives both levels strongly
// - mode seven: resistive both ways
// - regulated special pins lose resistive modes
// - data from register or bypass signal
// - port-wide registers, one bit per pin
// - pin-form register aliases same settings
// - control bus enable switches to high-z input
// - sixteen enables routable to any pin
// - per-pin slew for strong/open-drain only
// - one interrupt unit per port
// - per-pin rising, falling, both or none
// - edge sets status bit, raises request
// - edge only, no level interrupts
// - port threshold select, always hysteresis
// - per-pin input buffer disable
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/10ps
module ppd_port
    import ppd_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    input  wire logic [11:0]       paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [NPIN-1:0]   pinIn,
    output logic      [NPIN-1:0]   pinOut,
    output logic      [NPIN-1:0]   pinOe,
    output logic      [NPIN-1:0]   pinResUp,
    output logic      [NPIN-1:0]   pinResDn,
    output logic      [NPIN-1:0]   pinSlowSlew,
    output logic      [NPIN-1:0]   pinInBufEn,
    output logic                   lvttlSelect,
    input  wire logic [NPIN-1:0]   bypassData,
    input  wire logic [NOE-1:0]    auxOe,
    output logic      [NPIN-1:0]   systemIn,
    output logic                   portIrq
);
    typedef struct packed {
        logic [NPIN-1:0]   dr;
        logic [NPIN-1:0]   dm0;
        logic [NPIN-1:0]   dm1;
        logic [NPIN-1:0]   dm2;
        logic [NPIN-1:0]   slw;
        logic [NPIN-1:0]   byp;
        logic [NPIN-1:0]   bie;
        logic [NPIN-1:0]   inDis;
        logic [NPIN-1:0]   sioReg;
        logic              lvttl;
        logic [2*NPIN-1:0] itype;
        logic [NPIN-1:0]   istat;
        logic [4*NPIN-1:0] oeSel;
        logic [NPIN-1:0]   sync1;
        logic [NPIN-1:0]   sync2;
        logic [NPIN-1:0]   prev;
        logic [31:0]       rdata;
        logic              ready;
        logic              err;
        logic [NPIN-1:0]   out;
        logic [NPIN-1:0]   oe;
        logic [NPIN-1:0]   resUp;
        logic [NPIN-1:0]   resDn;
        logic [NPIN-1:0]   slow;
        logic [NPIN-1:0]   inEn;
        logic [NPIN-1:0]   sysIn;
        logic              irq;
    } ppd_state_t;

    ppd_state_t st;
    ppd_state_t next_st;

    logic [NPIN-1:0] edgeHit;
    logic [NPIN-1:0] inOn;
    logic [NPIN-1:0] drvOut;
    logic [NPIN-1:0] drvOe;
    logic [NPIN-1:0] drvUp;
    logic [NPIN-1:0] drvDn;
    logic [NPIN-1:0] drvSlow;
    logic [NPIN-1:0] auxOn;

    genvar g;
    generate
        for (g = 0; g < NPIN; g++)
        begin : gPin
            ppd_mode_t mode;
            logic      data;
            logic      bidirIn;
            logic      rise;
            logic      fall;
            assign mode = ppd_mode_t'({st.dm2[g], st.dm1[g],
                                       st.dm0[g]});
            assign data = st.byp[g] ? bypassData[g] : st.dr[g];
            assign auxOn[g] = auxOe[st.oeSel[4*g +: 4]];
            // enable low forces high-z; the input buffer still follows the drive mode
            assign bidirIn = st.bie[g] & ~auxOn[g];
            always_comb
            begin
                drvOut[g] = data;
                drvOe[g]  = 1'b0;
                drvUp[g]  = 1'b0;
                drvDn[g]  = 1'b0;
                if (!bidirIn)
                begin
                    case (mode)
                        DM_HIZ_ANA: drvOe[g] = 1'b0;
                        DM_HIZ_DIG: drvOe[g] = 1'b0;
                        DM_RES_UP:
                        begin
                            drvOe[g] = ~data;
                            drvUp[g] = data & ~st.sioReg[g];
                        end
                        DM_RES_DN:
                        begin
                            drvOe[g] = data;
                            drvDn[g] = ~data & ~st.sioReg[g];
                        end
                        DM_OD_LO: drvOe[g] = ~data;
                        DM_OD_HI: drvOe[g] = data;
                        DM_STRONG: drvOe[g] = 1'b1;
                        DM_RES_UD:
                        begin
                            drvUp[g] = data & ~st.sioReg[g];
                            drvDn[g] = ~data & ~st.sioReg[g];
                        end
                        default: drvOe[g] = 1'b0;
                    endcase
                end
            end
            // slew only matters in strong and open-drain
            assign drvSlow[g] = ~st.slw[g] & mode[2]
                                & ~(mode[1] & mode[0]);
            assign inOn[g] = (mode != DM_HIZ_ANA)
                             & ~st.inDis[g];
            // edge only; no level behaviour anywhere in this block
            assign rise = st.sync2[g] & ~st.prev[g] & inOn[g];
            assign fall = ~st.sync2[g] & st.prev[g] & inOn[g];
            always_comb
            begin
                case (st.itype[2*g +: 2])
                    IT_RISE: edgeHit[g] = rise;
                    IT_FALL: edgeHit[g] = fall;
                    IT_BOTH: edgeHit[g] = rise | fall;
                    default: edgeHit[g] = 1'b0;
                endcase
            end
        end
    endgenerate

    logic        acc;
    logic        wr;
    logic        pinHit;
    logic [2:0]  pinIdx;
    logic [31:0] rd;
    logic        bad;
    logic        istatRd;

    assign acc    = psel & penable & ~st.ready;
    assign wr     = acc & pwrite;
    assign pinHit = paddr[11:5] == OFS_PIN[11:5];
    assign pinIdx = paddr[4:2];
    assign istatRd = acc & ~pwrite & ~pinHit & (paddr == OFS_ISTAT);

    always_comb
    begin
        next_st = st;
        rd  = 32'h0000_0000;
        bad = 1'b0;
        // pin form gathers this pin's most-used bits
        if (pinHit)
        begin
            rd[PF_DR]  = st.dr[pinIdx];
            rd[PF_PS]  = st.sync2[pinIdx];
            rd[PF_DM]  = st.dm0[pinIdx];
            rd[PF_DM+1] = st.dm1[pinIdx];
            rd[PF_DM+2] = st.dm2[pinIdx];
            rd[PF_SLW] = st.slw[pinIdx];
            rd[PF_BIE] = st.bie[pinIdx];
            rd[PF_BYP] = st.byp[pinIdx];
        end
        else
        begin
            case (paddr)
                OFS_DR:    rd[NPIN-1:0] = st.dr;
                OFS_DM0:   rd[NPIN-1:0] = st.dm0;
                OFS_DM1:   rd[NPIN-1:0] = st.dm1;
                OFS_DM2:   rd[NPIN-1:0] = st.dm2;
                OFS_SLW:   rd[NPIN-1:0] = st.slw;
                OFS_BYP:   rd[NPIN-1:0] = st.byp;
                OFS_BIE:   rd[NPIN-1:0] = st.bie;
                OFS_INDIS: rd[NPIN-1:0] = st.inDis;
                OFS_CTL:   rd[0] = st.lvttl;
                OFS_PS:    rd[NPIN-1:0] = st.sync2;
                OFS_ITYP:  rd[2*NPIN-1:0] = st.itype;
                OFS_ISTAT: rd[NPIN-1:0] = st.istat;
                OFS_SIOREG: rd[NPIN-1:0] = st.sioReg;
                OFS_OESEL: rd = st.oeSel;
                default:   bad = 1'b1;
            endcase
        end
        if (wr)
        begin
            if (pinHit)
            begin
                next_st.dr[pinIdx]  = pwdata[PF_DR];
                next_st.dm0[pinIdx] = pwdata[PF_DM];
                next_st.dm1[pinIdx] = pwdata[PF_DM+1];
                next_st.dm2[pinIdx] = pwdata[PF_DM+2];
                next_st.slw[pinIdx] = pwdata[PF_SLW];
                next_st.bie[pinIdx] = pwdata[PF_BIE];
                next_st.byp[pinIdx] = pwdata[PF_BYP];
            end
            else
            begin
                case (paddr)
                    OFS_DR:    next_st.dr = pwdata[NPIN-1:0];
                    OFS_DM0:   next_st.dm0 = pwdata[NPIN-1:0];
                    OFS_DM1:   next_st.dm1 = pwdata[NPIN-1:0];
                    OFS_DM2:   next_st.dm2 = pwdata[NPIN-1:0];
                    OFS_SLW:   next_st.slw = pwdata[NPIN-1:0];
                    OFS_BYP:   next_st.byp = pwdata[NPIN-1:0];
                    OFS_BIE:   next_st.bie = pwdata[NPIN-1:0];
                    OFS_INDIS: next_st.inDis = pwdata[NPIN-1:0];
                    OFS_CTL:   next_st.lvttl = pwdata[0];
                    OFS_ITYP:  next_st.itype = pwdata[2*NPIN-1:0];
                    OFS_SIOREG: next_st.sioReg = pwdata[NPIN-1:0];
                    OFS_OESEL: next_st.oeSel = pwdata;
                    default:   next_st.istat = st.istat;
                endcase
            end
        end
        // status clears on read; a same-cycle edge still wins
        if (istatRd)
            next_st.istat = 8'h00;
        next_st.istat = next_st.istat | edgeHit;
        next_st.irq   = |next_st.istat;
        next_st.ready = acc;
        next_st.err   = acc & bad;
        next_st.rdata = acc ? rd : 32'h0000_0000;
        // two-stage sync keeps each edge to one hit
        next_st.sync1 = pinIn;
        next_st.sync2 = st.sync1;
        next_st.prev  = st.sync2;
        next_st.out   = drvOut;
        next_st.oe    = drvOe;
        next_st.resUp = drvUp;
        next_st.resDn = drvDn;
        next_st.slow  = drvSlow;
        next_st.inEn  = inOn;
        next_st.sysIn = st.sync2 & inOn;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign prdata      = st.rdata;
    assign pready      = st.ready;
    assign pslverr     = st.err;
    assign pinOut      = st.out;
    assign pinOe       = st.oe;
    assign pinResUp    = st.resUp;
    assign pinResDn    = st.resDn;
    assign pinSlowSlew = st.slow;
    assign pinInBufEn  = st.inEn;
    assign lvttlSelect = st.lvttl;
    assign systemIn    = st.sysIn;
    assign portIrq     = st.irq;

    a_strong_drive: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        st.dm2 == 8'hFF && st.dm1 == 8'hFF && st.dm0 == 8'h00 && st.bie == 8'h00
        |=> pinOe == 8'hFF)
        else $error("strong mode not driving");

    a_edge_status: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        |edgeHit
        |=> (st.istat & $past(edgeHit)) == $past(edgeHit))
        else $error("edge did not set status");

    a_irq_follow: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        $rose(|st.istat)
        |-> portIrq)
        else $error("irq not raised");

    a_analog_noin: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        1'b1
        |=> (systemIn & ~$past(inOn)) == 8'h00)
        else $error("input seen with buffer off");

    a_ready_pulse: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        pready
        |=> !pready)
        else $error("ready held past one cycle");

    a_err_ready: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        pslverr
        |-> pready)
        else $error("error without ready");

    a_analog_nodrive: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (st.dm0 | st.dm1 | st.dm2) == 8'h00
        |=> (pinOe | pinResUp | pinResDn | pinInBufEn) == 8'h00)
        else $error("analog mode drives or senses");

    a_sio_nopull: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        st.sioReg == 8'hFF
        |=> (pinResUp | pinResDn) == 8'h00)
        else $error("pull on regulated pin");

    a_slew_gate: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (pinSlowSlew & (pinResUp | pinResDn))
        == 8'h00)
        else $error("slow slew in resistive mode");

    a_pull_excl: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (pinResUp & pinResDn)
        == 8'h00)
        else $error("both pulls on one pin");

    a_status_hold: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        !istatRd
        |=> (st.istat & $past(st.istat)) == $past(st.istat))
        else $error("status lost without read");

    a_status_source: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        1'b1
        |=> (st.istat & ~$past(st.istat) & ~$past(edgeHit)) == 8'h00)
        else $error("status set without edge");

    a_bidir_hiz: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        1'b1
        |=> ((pinOe | pinResUp | pinResDn) & $past(st.bie & ~auxOn)) == 8'h00)
        else $error("drive while bus enable low");

    a_bypass_data: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        1'b1
        |=> (pinOut & $past(st.byp)) == ($past(bypassData) & $past(st.byp)))
        else $error("bypass data not passed");

    a_od_low: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        st.dm2 == 8'hFF && st.dm1 == 8'h00 && st.dm0 == 8'h00
        |=> (pinOe & pinOut) == 8'h00)
        else $error("open drain low drove high");

endmodule

// ---- verif/ppd_pin_model.sv ----
// outside circuit on the port pins: resolves each pin level
`timescale 1ns/10ps
module ppd_pin_model
    import ppd_pkg::*;
(
    input  wire logic            clk_sys,
    input  wire logic [NPIN-1:0] pinOut,
    input  wire logic [NPIN-1:0] pinOe,
    input  wire logic [NPIN-1:0] pinResUp,
    input  wire logic [NPIN-1:0] pinResDn,
    input  wire logic [NPIN-1:0] extLvl,
    input  wire logic [NPIN-1:0] extEn,
    output logic      [NPIN-1:0] pinIn
);
    logic [NPIN-1:0] flt = '0;
    // a floating pin wanders, so it never shows a steady level
    always_ff @(posedge clk_sys)
        flt <= ~flt;
    // strong drive beats the outside; outside beats the 5K pulls
    always_comb
        for (int i = 0; i < NPIN; i++)
            if (pinOe[i])
                pinIn[i] = pinOut[i];
            else if (extEn[i])
                pinIn[i] = extLvl[i];
            else if (pinResUp[i] || pinResDn[i])
                pinIn[i] = pinResUp[i];
            else
                pinIn[i] = flt[i];
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the port pin block
`timescale 1ns/10ps
`define CHK(n,e,g) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_top
    import ppd_pkg::*;
;
    logic clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, lvttlSelect, portIrq, e;
    logic [7:0] pinIn, pinOut, pinOe, pinResUp, pinResDn, pinSlowSlew;
    logic [7:0] pinInBufEn, systemIn, bypassData = '0, extLvl = '0;
    logic [7:0] extEn = '0;
    logic [15:0] auxOe = '0;
    int num_errors = 0, checks = 0;
    ppd_port ppd_port_inst (
        .clk_sys     (clk_sys),
        .arst_n      (arst_n),
        .paddr       (paddr),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .pinIn       (pinIn),
        .pinOut      (pinOut),
        .pinOe       (pinOe),
        .pinResUp    (pinResUp),
        .pinResDn    (pinResDn),
        .pinSlowSlew (pinSlowSlew),
        .pinInBufEn  (pinInBufEn),
        .lvttlSelect (lvttlSelect),
        .bypassData  (bypassData),
        .auxOe       (auxOe),
        .systemIn    (systemIn),
        .portIrq     (portIrq)
    );
    ppd_pin_model ppd_pin_model_inst (
        .clk_sys     (clk_sys),
        .pinOut      (pinOut),
        .pinOe       (pinOe),
        .pinResUp    (pinResUp),
        .pinResDn    (pinResDn),
        .extLvl      (extLvl),
        .extEn       (extEn),
        .pinIn       (pinIn)
    );
    initial
        forever #5 clk_sys = ~clk_sys;
    task finish_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
        if (n >= 20)
        begin
            num_errors++;
            finish_test();
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task settle(); // outputs lag the register write
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task mode_all(input int m);
        wr(OFS_DM0, m[0] ? 32'h000000FF : 32'h0);
        wr(OFS_DM1, m[1] ? 32'h000000FF : 32'h0);
        wr(OFS_DM2, m[2] ? 32'h000000FF : 32'h0);
    endtask
    function automatic logic [2:0] exd(input int m, input logic d);
        case (m) // oe, pull up, pull down
            2: exd = d ? 3'h2 : 3'h4;
            3: exd = d ? 3'h4 : 3'h1;
            4: exd = d ? 3'h0 : 3'h4;
            5: exd = d ? 3'h4 : 3'h0;
            6: exd = 3'h4;
            7: exd = d ? 3'h2 : 3'h1;
            default: exd = 3'h0;
        endcase
    endfunction
    task t_modes();
        logic [2:0] x;
        logic [7:0] eo, eu, ed;
        wr(OFS_DR, 32'h0000000F);
        for (int m = 0; m < 8; m++)
        begin
            mode_all(m);
            settle();
            for (int i = 0; i < 8; i++)
            begin
                x = exd(m, i < 4);
                {eo[i], eu[i], ed[i]} = x;
            end
            `CHK("oe", eo, pinOe)
            `CHK("up", eu, pinResUp)
            `CHK("dn", ed, pinResDn)
            `CHK("out", 8'h0F & eo, pinOut & pinOe)
            `CHK("ibuf", m == 0 ? 8'h00 : 8'hFF, pinInBufEn)
        end
        wr(OFS_SIOREG, 32'h000000FF);
        settle();
        `CHK("sio", 8'h00, pinResUp | pinResDn)
        wr(OFS_SIOREG, 32'h0);
        $display("test modes done");
    endtask
    task t_paths();
        mode_all(6);
        wr(OFS_DR, 32'h000000FF);
        bypassData <= 8'h55;
        wr(OFS_BYP, 32'h000000FF);
        wr(OFS_SLW, 32'h0000000F);
        wr(OFS_CTL, 32'h00000001);
        settle();
        `CHK("byp", 8'h55, pinOut)
        `CHK("slew", 8'hF0, pinSlowSlew)
        `CHK("lvttl", 1'b1, lvttlSelect)
        wr(OFS_BYP, 32'h0);
        wr(OFS_BIE, 32'h000000FF);
        wr(OFS_OESEL, 32'h76543210);
        auxOe <= 16'h00A5;
        settle();
        `CHK("bidir", 8'hA5, pinOe)
        wr(OFS_OESEL, 32'hFFFFFFFF);
        auxOe <= 16'h8000;
        settle();
        `CHK("oe15", 8'hFF, pinOe)
        wr(OFS_BIE, 32'h0);
        wr(OFS_PIN + 12'h00C, 32'h00000010);
        settle();
        `CHK("pf", 2'h1, {pinOut[3], pinOe[3]})
        apb(0, OFS_DM1, 32'h0);
        `CHK("dm1", 8'hF7, q[7:0])
        apb(0, OFS_DR, 32'h0);
        `CHK("dr", 8'hF7, q[7:0])
        apb(0, 12'h0FC, 32'h0);
        `CHK("slverr", 1'b1, e)
        $display("test paths done");
    endtask
    task edge_wait(input logic [7:0] v);
        extLvl <= v;
        repeat (6) @(posedge clk_sys);
        #1;
    endtask
    task t_irq();
        mode_all(1);
        extEn <= 8'hFF;
        wr(OFS_ITYP, 32'h00000039); // rise, fall, both, none
        settle();
        apb(0, OFS_ISTAT, 32'h0);
        edge_wait(8'h0F);
        `CHK("irq", 1'b1, portIrq)
        apb(0, OFS_ISTAT, 32'h0);
        `CHK("rise", 8'h05, q[7:0])
        apb(0, OFS_ISTAT, 32'h0);
        `CHK("once", 8'h00, q[7:0])
        wr(OFS_INDIS, 32'h00000001);
        settle();
        `CHK("irqlo", 1'b0, portIrq)
        `CHK("sysin", 8'h0E, systemIn)
        edge_wait(8'h00);
        apb(0, OFS_ISTAT, 32'h0);
        `CHK("fall", 8'h06, q[7:0])
        $display("test irq done");
    endtask
    initial
    begin
        repeat (5) @(posedge clk_sys);
        arst_n <= 1;
        #1;
        `CHK("rst", 8'h00, pinOe | pinResUp | pinResDn | pinInBufEn)
        t_modes();
        t_paths();
        t_irq();
        finish_test();
    end
endmodule
